/* iec_apb_decode.sv */
// Module: APB address decoder for the enable bank; single-cycle command out.
// Assumes requests come from logic on pclk; no synchroniser is needed.
`timescale 1ns/100ps
module iec_apb_decode
  import iec_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  iec_pkg::iec_apb_req_t req,
  output iec_pkg::iec_wr_cmd_t  cmd,
  output logic              addr_hit,
  output logic              addr_is_status
);

  logic access;

  assign access = req.psel && req.penable && req.pwrite;

  // =========================================================================
  // Decode
  // =========================================================================
  always_comb begin
    cmd            = '0;
    addr_hit       = 1'b0;
    addr_is_status = 1'b0;
    if (req.paddr == IEC_OFF_ENABLE_CLEAR) begin
      addr_hit     = 1'b1;
      cmd.wr_clear = access;
    end else if (req.paddr == IEC_OFF_ENABLE_SET) begin
      addr_hit   = 1'b1;
      cmd.wr_set = access;
    end else if (req.paddr == IEC_OFF_LINE_STATUS) begin
      addr_hit       = 1'b1;
      addr_is_status = 1'b1;
    end
    // Upper bits are unimplemented and never reach the mask
    cmd.mask = req.pwdata[IEC_NUM_LINES-1:0];
  end

endmodule

/* iec_assertions.sv */
// Checker: port properties of the enable-clear bank.
// Assumes it is bound to iec_top and sees only its ports.
`timescale 1ns/100ps
module iec_checker
  import iec_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [17:0] line_request,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [17:0] line_enable,
  input wire logic [17:0] line_taken
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Properties
  a_reset_clear: assert property (
    $rose(presetn) |-> line_enable == 18'h0 && prdata == 32'h0)
    else $error("Outputs not clear after reset");
  a_high_zero: assert property (
    pready |-> prdata[31:18] == 14'h0)
    else $error("Upper read bits not zero");
  a_read_enables: assert property (
    psel && !penable && !pwrite && paddr == IEC_OFF_ENABLE_CLEAR
    |=> prdata[17:0] == line_enable)
    else $error("Read data differs from enables");
  a_clear_ones: assert property (
    psel && penable && pwrite && paddr == IEC_OFF_ENABLE_CLEAR
    |=> ##1 (line_enable & $past(pwdata[17:0], 2)) == 18'h0)
    else $error("Line not cleared");
  a_zero_keep: assert property (
    psel && penable && pwrite && paddr == IEC_OFF_ENABLE_CLEAR
    |=> ##1 ((line_enable ^ $past(line_enable)) & ~$past(pwdata[17:0], 2)) == 18'h0)
    else $error("Unselected line changed");
  a_line_map: assert property (
    line_taken == ($past(line_request) & line_enable))
    else $error("Taken lines differ from enables");
  a_ready_next: assert property (
    psel && !penable |=> pready)
    else $error("No ready after setup cycle");
  a_ready_single: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle");
  a_status_read: assert property (
    psel && !penable && !pwrite && paddr == IEC_OFF_LINE_STATUS
    |=> prdata[17:0] == $past(line_request))
    else $error("Status read differs from lines");
  a_unmapped_err: assert property (
    psel && !penable && paddr != IEC_OFF_ENABLE_CLEAR && paddr != IEC_OFF_ENABLE_SET
    && paddr != IEC_OFF_LINE_STATUS |=> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");
endmodule

/* iec_enable_bank.sv */
// Module: per-line enable flip-flops shared by the set and clear views.
// Assumes write commands are single-cycle pulses on pclk.
`timescale 1ns/100ps
module iec_enable_bank
  import iec_pkg::*;
#(
  parameter int N = IEC_NUM_LINES
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  iec_pkg::iec_wr_cmd_t  cmd,
  output logic [N-1:0]      enable_q
);

  logic [N-1:0] enable_reg;
  logic [N-1:0] enable_next;

  // =========================================================================
  // Next state: set or clear on ones, zeros leave lines alone
  // =========================================================================
  always_comb begin
    enable_next = enable_reg;
    if (cmd.wr_set) begin
      enable_next = enable_next | cmd.mask[N-1:0];
    end
    if (cmd.wr_clear) begin
      enable_next = enable_next & ~cmd.mask[N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= IEC_ENABLE_RESET[N-1:0];
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign enable_q = enable_reg;

endmodule

/* iec_pkg.sv */
// Package: constants and carrier types for the interrupt enable-clear bank.
// Assumes a 32-bit APB register bus and one system clock.
package iec_pkg;

  // =========================================================================
  // Register map
  // =========================================================================
  localparam logic [11:0] IEC_OFF_ENABLE_CLEAR = 12'h000;
  localparam logic [11:0] IEC_OFF_ENABLE_SET   = 12'h004;
  localparam logic [11:0] IEC_OFF_LINE_STATUS  = 12'h008;

  // =========================================================================
  // Field layout and reset values
  // =========================================================================
  localparam int          IEC_NUM_LINES    = 18;
  localparam int          IEC_FIRST_LINE   = 32;
  localparam int          IEC_LAST_LINE    = 49;
  localparam logic [17:0] IEC_ENABLE_RESET = 18'h00000;
  localparam logic [31:0] IEC_ZERO_WORD    = 32'h00000000;

  // =========================================================================
  // Carrier types
  // =========================================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } iec_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } iec_apb_rsp_t;

  typedef struct packed {
    logic        wr_clear;
    logic        wr_set;
    logic [17:0] mask;
  } iec_wr_cmd_t;

endpackage

/* iec_tb_top.sv */
// Testbench: random and corner APB traffic on the enable-clear bank.
// Assumes the offsets of iec_pkg and the clear-wins order of iec_enable_bank.
`timescale 1ns/100ps
module iec_tb_top;
  import iec_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, s, c;
  logic [17:0] line_request = 18'h0, line_enable, line_taken, en;
  int n_fail = 0, check_count = 0, i;
  iec_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .line_request(line_request),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_enable(line_enable),
    .line_taken(line_taken));
  always #2.5 pclk = ~pclk;
  // ==========
  // Tasks
  task summarize;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  function automatic logic [17:0] model_set(input logic [17:0] cur, input logic [31:0] wd);
    return cur | wd[17:0];
  endfunction
  function automatic logic [17:0] model_clear(input logic [17:0] cur, input logic [31:0] wd);
    return cur & ~wd[17:0];
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k < 20) begin
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end else begin
      n_fail++;
      summarize();
    end
  endtask
  // ==========
  // Sequence
  initial begin
    void'($urandom(32'hb2c7));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, IEC_OFF_ENABLE_CLEAR, 32'h0);
    chk("reset", 32'h0, r);
    $display("test reset done");
    en = 18'h0;
    for (i = 0; i < 40; i++) begin
      s = (i < 18) ? 32'hffffffff : $urandom;
      c = (i < 18) ? (32'h1 << i) | 32'hfffc0000 : $urandom;
      apb(1, IEC_OFF_ENABLE_SET, s);
      en = model_set(en, s);
      chk("set_err", 32'h0, {31'h0, e});
      apb(0, IEC_OFF_ENABLE_SET, 32'h0);
      chk("set_view", {14'h0, en}, r);
      apb(1, IEC_OFF_ENABLE_CLEAR, c);
      en = model_clear(en, c);
      apb(0, IEC_OFF_ENABLE_CLEAR, 32'h0);
      chk("enables", {14'h0, en}, r);
      line_request <= 18'($urandom);
      repeat (3) @(posedge pclk);
      chk("taken", {14'h0, line_request & en}, {14'h0, line_taken});
      chk("line_enable", {14'h0, en}, {14'h0, line_enable});
      apb(0, IEC_OFF_LINE_STATUS, 32'h0);
      chk("status", {14'h0, line_request}, r);
    end
    $display("test random done");
    apb(1, IEC_OFF_LINE_STATUS, 32'hffffffff);
    chk("status_err", 32'h0, {31'h0, e});
    apb(1, 12'h00c, 32'hffffffff);
    chk("error", 32'h1, {31'h0, e});
    apb(0, 12'h00c, 32'h0);
    chk("unmapped_read", 32'h0, r);
    apb(0, IEC_OFF_ENABLE_CLEAR, 32'h0);
    chk("kept", {14'h0, en}, r);
    // Enable every line so the reset below has something to clear
    apb(1, IEC_OFF_ENABLE_SET, 32'hffffffff);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    en = 18'h0;
    apb(0, IEC_OFF_ENABLE_CLEAR, 32'h0);
    chk("rereset", 32'h0, r);
    chk("rereset_line", 32'h0, {14'h0, line_enable});
    $display("test unmapped and reset done");
    summarize();
  end
endmodule
bind iec_top iec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .line_request(line_request), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_enable(line_enable), .line_taken(line_taken));

/* iec_top.sv */
// Function
// - Bits 0..17 map to lines 32..49.
// - Writing one disables the matching line.
// - Writing zero leaves the line unchanged.
// - Read returns each line's enable state.
//
// Top: APB slave holding the enable-clear register for interrupt lines 32..49.
// Assumes an APB master on pclk; line_enable feeds the interrupt arbiter.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
module iec_top
  import iec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [17:0] line_request,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [17:0]      line_enable,
  output logic [17:0]      line_taken
);

  iec_apb_req_t req;
  iec_wr_cmd_t  cmd;
  logic         addr_hit;
  logic         addr_is_status;
  logic [17:0]  enable_q;

  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pready_reg;
  logic         pready_next;
  logic         pslverr_reg;
  logic         pslverr_next;
  logic [17:0]  taken_reg;
  logic [17:0]  taken_next;

  function automatic logic [31:0] iec_widen(input logic [17:0] bits);
    iec_widen = {14'h0000, bits};
  endfunction

  assign req.psel    = psel;
  assign req.penable = penable;
  assign req.pwrite  = pwrite;
  assign req.paddr   = paddr;
  assign req.pwdata  = pwdata;

  // =========================================================================
  // Decode and enable storage
  // =========================================================================
  iec_apb_decode u_decode (
    .pclk           (pclk),
    .presetn        (presetn),
    .req            (req),
    .cmd            (cmd),
    .addr_hit       (addr_hit),
    .addr_is_status (addr_is_status)
  );

  iec_enable_bank #(
    .N (IEC_NUM_LINES)
  ) u_bank (
    .pclk     (pclk),
    .presetn  (presetn),
    .cmd      (cmd),
    .enable_q (enable_q)
  );

  // =========================================================================
  // APB answer: ready in the setup cycle's following access cycle
  // =========================================================================
  always_comb begin
    prdata_next  = IEC_ZERO_WORD;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pready_next  = 1'b1;
      pslverr_next = !addr_hit;
      if (!pwrite && addr_hit) begin
        if (addr_is_status) begin
          prdata_next = iec_widen(line_request);
        end else begin
          prdata_next = iec_widen(enable_q);
        end
      end
    end
  end

  // Lines taken only while enabled; a cleared line stops one cycle after enable_q clears, with line_enable
  always_comb begin
    taken_next = line_request & enable_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= IEC_ZERO_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      taken_reg   <= IEC_ENABLE_RESET;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      taken_reg   <= taken_next;
    end
  end

  logic [17:0] enable_out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_out_reg <= IEC_ENABLE_RESET;
    end else begin
      enable_out_reg <= enable_q;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign line_enable = enable_out_reg;
  assign line_taken  = taken_reg;

endmodule
